// ---- rtl/bmpm_pkg.sv ----
// Notes on behaviour
// - Bus mode fixed from third strap at reset.
// - Strap low: 14 address outputs, 24 data pins.
// - Full mode: upper data byte carries byte address.
// - Strap high: sixteen-pin host address/data port.
// - Host mode keeps address bit zero, upper data.
// - Straps read once, on the first edge after reset, then flags.
// - Masked interrupt fires from pin, own flag too.
// - Sense: selectable, two level, one edge only.
// - Control register swaps serial port for interrupts, flags.
// - Bus pins fixed; serial pins reconfigurable any time.
package bmpm_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          BMPM_AW         = 5;
  localparam logic [4:0]  BMPM_OFS_SYSCTL = 5'h00;
  localparam logic [4:0]  BMPM_OFS_FDIR   = 5'h04;
  localparam logic [4:0]  BMPM_OFS_FOUT   = 5'h08;
  localparam logic [4:0]  BMPM_OFS_FIN    = 5'h0C;
  localparam logic [4:0]  BMPM_OFS_MODE   = 5'h10;
  localparam logic [4:0]  BMPM_OFS_STAT   = 5'h14;
  localparam logic [4:0]  BMPM_OFS_MASK   = 5'h18;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          BMPM_SC_SP_ALT    = 0;
  localparam int          BMPM_SC_SEL_EDGE  = 1;
  localparam int          BMPM_SC_SIRQ0_EDG = 2;
  localparam int          BMPM_SC_SIRQ1_EDG = 3;
  localparam int          BMPM_SC_FLAG_OUT  = 4;
  localparam int          BMPM_STRAP_HOST   = 2;
  localparam int          BMPM_FIN_FLAG_IN  = 8;
  localparam int          BMPM_MODE_HOST    = 3;
  localparam logic [4:0]  BMPM_SYSCTL_RST   = 5'h00;
  localparam logic [7:0]  BMPM_FDIR_RST     = 8'h00;
  localparam logic [7:0]  BMPM_FOUT_RST     = 8'h00;
  localparam logic [5:0]  BMPM_MASK_RST     = 6'h00;

  // Interrupt bit order in status and mask.
  localparam int          BMPM_NIRQ         = 6;
  localparam int          BMPM_I_SEL        = 0;
  localparam int          BMPM_I_LVL1       = 1;
  localparam int          BMPM_I_LVL0       = 2;
  localparam int          BMPM_I_EDGE       = 3;
  localparam int          BMPM_I_SIRQ0      = 4;
  localparam int          BMPM_I_SIRQ1      = 5;

  // Flag pins that also carry interrupts.
  localparam int          BMPM_PF_SEL       = 7;
  localparam int          BMPM_PF_LVL1      = 6;
  localparam int          BMPM_PF_LVL0      = 5;
  localparam int          BMPM_PF_EDGE      = 4;

  // Data pins that carry the host strobes in host mode.
  localparam int          BMPM_D_WR         = 7;
  localparam int          BMPM_D_RD         = 6;
  localparam int          BMPM_D_AL         = 5;
  localparam int          BMPM_D_SEL        = 4;
  localparam int          BMPM_D_ACK        = 3;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] wdata;
    logic        wdata_oe;
    logic        byte_access;
    logic [7:0]  byte_addr_hi;
  } bmpm_mem_core_t;

  typedef struct packed {
    logic [15:0] ad_in;
    logic        host_write_strobe_n;
    logic        host_read_strobe_n;
    logic        host_addr_latch;
    logic        host_port_select_n;
  } bmpm_host_out_t;

  typedef struct packed {
    logic [15:0] ad_out;
    logic        ad_oe;
    logic        host_port_ack_n;
  } bmpm_host_in_t;

  typedef struct packed {
    logic                 started;
    logic [2:0]           strap;
    logic [4:0]           sysctl;
    logic [7:0]           fdir;
    logic [7:0]           fout;
    logic [BMPM_NIRQ-1:0] stat;
    logic [BMPM_NIRQ-1:0] mask;
    logic                 dph_wr;
    logic [BMPM_AW-1:0]   dph_addr;
    logic [31:0]          rdata;
  } bmpm_state_t;

endpackage

// ---- rtl/bmpm_irq_sense.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmpm_irq_sense
  import bmpm_pkg::*;
#(
  parameter int N = 6
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // Request levels and sense selection
  input  wire logic [N-1:0] i_asserted,
  input  wire logic [N-1:0] i_edge_mode,
  // Events
  output logic      [N-1:0] o_event
);

  typedef struct packed {
    logic [N-1:0] prev;
  } bmpm_sense_t;

  bmpm_sense_t st_ff;
  bmpm_sense_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = i_asserted;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // An edge-mode input fires once on assertion; a level-mode one for as long as it is held.
  assign o_event = (i_edge_mode & i_asserted & ~st_ff.prev) | (~i_edge_mode & i_asserted);

endmodule
`default_nettype wire

// ---- rtl/bmpm_pin_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmpm_pin_mux
  import bmpm_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // AHB-Lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // Interrupt outputs
  output logic                      o_irq,
  output logic      [BMPM_NIRQ-1:0] o_vector_req,
  // Flag pins; bits 2..0 are the mode straps during reset
  input  wire logic [7:0]           i_flag_pin,
  output logic      [7:0]           o_flag_pin,
  output logic      [7:0]           o_flag_pin_oe_n,
  // External address and data pins
  input  wire logic [13:0]          i_addr_pin,
  output logic      [13:0]          o_addr_pin,
  output logic      [13:0]          o_addr_pin_oe_n,
  input  wire logic [23:0]          i_data_pin,
  output logic      [23:0]          o_data_pin,
  output logic      [23:0]          o_data_pin_oe_n,
  // Core memory side
  input  wire bmpm_mem_core_t       i_core_mem,
  output logic      [23:0]          o_core_rdata,
  output logic                      o_host_mode,
  // Internal memory access port side
  input  wire bmpm_host_in_t        i_host,
  output bmpm_host_out_t            o_host,
  // Second serial port pins
  input  wire logic                 i_sp1_rfs_pin,
  input  wire logic                 i_sp1_dr_pin,
  input  wire logic                 i_sp1_tfs_pin,
  output logic                      o_sp1_tfs_pin,
  output logic                      o_sp1_tfs_pin_oe_n,
  output logic                      o_sp1_dt_pin,
  output logic                      o_sp1_dt_pin_oe_n,
  // Second serial port core side
  input  wire logic                 i_sport_tfs,
  input  wire logic                 i_sport_tfs_oe,
  input  wire logic                 i_sport_dt,
  input  wire logic                 i_sport_dt_oe,
  output logic                      o_sport_rfs,
  output logic                      o_sport_dr,
  output logic                      o_sport_tfs
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rd_mux(input bmpm_state_t s, input logic [BMPM_AW-1:0] a,
                                         input logic [7:0] fpins, input logic serial_in);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == BMPM_OFS_SYSCTL) begin
      r[4:0] = s.sysctl;
    end else if (a == BMPM_OFS_FDIR) begin
      r[7:0] = s.fdir;
    end else if (a == BMPM_OFS_FOUT) begin
      r[7:0] = s.fout;
    end else if (a == BMPM_OFS_FIN) begin
      r[7:0]          = fpins;
      r[BMPM_FIN_FLAG_IN] = serial_in;
    end else if (a == BMPM_OFS_MODE) begin
      r[2:0]            = s.strap;
      r[BMPM_MODE_HOST] = s.strap[BMPM_STRAP_HOST];
    end else if (a == BMPM_OFS_STAT) begin
      r[BMPM_NIRQ-1:0] = s.stat;
    end else if (a == BMPM_OFS_MASK) begin
      r[BMPM_NIRQ-1:0] = s.mask;
    end
    return r;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  bmpm_state_t          st_ff;
  bmpm_state_t          nxt_st;
  logic                 sp_alt;
  logic                 host_mode;
  logic                 full_mode;
  logic                 addr_ph;
  logic [7:0]           flag_in;
  logic [BMPM_NIRQ-1:0] irq_asserted;
  logic [BMPM_NIRQ-1:0] irq_edge_mode;
  logic [BMPM_NIRQ-1:0] irq_event;
  logic [BMPM_NIRQ-1:0] w1c;

  assign sp_alt    = st_ff.sysctl[BMPM_SC_SP_ALT];
  // Neither mode is live until the straps have been caught, so the bus pins float in reset.
  assign host_mode = st_ff.started & st_ff.strap[BMPM_STRAP_HOST];
  assign full_mode = st_ff.started & ~st_ff.strap[BMPM_STRAP_HOST];
  assign addr_ph   = i_hsel & i_htrans[1] & i_hready;
  assign flag_in   = i_flag_pin;

  // ************************************************************
  // Interrupt sources
  // ************************************************************
  // The pin level is sampled after the pad, so a flag this block drives low raises
  // its own interrupt just as an outside driver would.
  always_comb begin
    irq_asserted                = '0;
    irq_asserted[BMPM_I_SEL]    = st_ff.started & ~flag_in[BMPM_PF_SEL];
    irq_asserted[BMPM_I_LVL1]   = st_ff.started & ~flag_in[BMPM_PF_LVL1];
    irq_asserted[BMPM_I_LVL0]   = st_ff.started & ~flag_in[BMPM_PF_LVL0];
    irq_asserted[BMPM_I_EDGE]   = st_ff.started & ~flag_in[BMPM_PF_EDGE];
    irq_asserted[BMPM_I_SIRQ0]  = st_ff.started & sp_alt & ~i_sp1_rfs_pin;
    irq_asserted[BMPM_I_SIRQ1]  = st_ff.started & sp_alt & ~i_sp1_tfs_pin;
  end

  always_comb begin
    irq_edge_mode               = '0;
    irq_edge_mode[BMPM_I_SEL]   = st_ff.sysctl[BMPM_SC_SEL_EDGE];
    irq_edge_mode[BMPM_I_EDGE]  = 1'b1;
    irq_edge_mode[BMPM_I_SIRQ0] = st_ff.sysctl[BMPM_SC_SIRQ0_EDG];
    irq_edge_mode[BMPM_I_SIRQ1] = st_ff.sysctl[BMPM_SC_SIRQ1_EDG];
  end

  bmpm_irq_sense #(
    .N           (BMPM_NIRQ)
  ) u_sense (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_asserted  (irq_asserted),
    .i_edge_mode (irq_edge_mode),
    .o_event     (irq_event)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    w1c    = '0;
    // The straps are caught on the first edge after reset release and never again.
    if (!st_ff.started) begin
      nxt_st.started = 1'b1;
      nxt_st.strap   = flag_in[2:0];
    end
    if (st_ff.dph_wr) begin
      if (st_ff.dph_addr == BMPM_OFS_SYSCTL) begin
        nxt_st.sysctl = i_hwdata[4:0];
      end else if (st_ff.dph_addr == BMPM_OFS_FDIR) begin
        nxt_st.fdir = i_hwdata[7:0];
      end else if (st_ff.dph_addr == BMPM_OFS_FOUT) begin
        nxt_st.fout = i_hwdata[7:0];
      end else if (st_ff.dph_addr == BMPM_OFS_STAT) begin
        w1c = i_hwdata[BMPM_NIRQ-1:0];
      end else if (st_ff.dph_addr == BMPM_OFS_MASK) begin
        nxt_st.mask = i_hwdata[BMPM_NIRQ-1:0];
      end
    end
    // A new event in the clearing cycle keeps its bit set.
    nxt_st.stat     = (st_ff.stat & ~w1c) | irq_event;
    nxt_st.dph_wr   = addr_ph & i_hwrite;
    nxt_st.dph_addr = addr_ph ? i_haddr[BMPM_AW-1:0] : st_ff.dph_addr;
    // Read data is taken from the next state so a read right after a write sees it.
    if (addr_ph && !i_hwrite) begin
      nxt_st.rdata = rd_mux(nxt_st, i_haddr[BMPM_AW-1:0], flag_in, i_sp1_dr_pin);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff          <= '0;
      st_ff.sysctl   <= BMPM_SYSCTL_RST;
      st_ff.fdir     <= BMPM_FDIR_RST;
      st_ff.fout     <= BMPM_FOUT_RST;
      st_ff.mask     <= BMPM_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Bus answer and interrupt output
  // ************************************************************
  assign o_hrdata     = st_ff.rdata;
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign o_vector_req = st_ff.stat & st_ff.mask;
  assign o_irq        = |(st_ff.stat & st_ff.mask);
  assign o_host_mode  = host_mode;

  // ************************************************************
  // Flag pins
  // ************************************************************
  // The straps stay undriven until captured, so a strap resistor is never fought.
  assign o_flag_pin      = st_ff.fout;
  assign o_flag_pin_oe_n = st_ff.started ? ~st_ff.fdir : 8'hFF;

  // ************************************************************
  // External bus pins
  // ************************************************************
  always_comb begin
    o_addr_pin      = 14'h0000;
    o_addr_pin_oe_n = 14'h3FFF;
    o_data_pin      = 24'h00_0000;
    o_data_pin_oe_n = 24'hFF_FFFF;
    o_host          = '0;
    o_host.host_write_strobe_n = 1'b1;
    o_host.host_read_strobe_n  = 1'b1;
    o_host.host_port_select_n  = 1'b1;
    if (full_mode) begin
      o_addr_pin      = i_core_mem.addr;
      o_addr_pin_oe_n = 14'h0000;
      o_data_pin      = i_core_mem.wdata;
      o_data_pin_oe_n = i_core_mem.wdata_oe ? 24'h00_0000 : 24'hFF_FFFF;
      if (i_core_mem.byte_access) begin
        o_data_pin[23:16]      = i_core_mem.byte_addr_hi;
        o_data_pin_oe_n[23:16] = 8'h00;
      end
    end else if (host_mode) begin
      // Only address bit zero stays an address; peripheral decode is left to the
      // board, which combines it with the host mode strap.
      o_addr_pin[0]      = i_core_mem.addr[0];
      o_addr_pin_oe_n[0] = 1'b0;
      o_data_pin[23:8]      = i_core_mem.wdata[23:8];
      o_data_pin_oe_n[23:8] = i_core_mem.wdata_oe ? 16'h0000 : 16'hFFFF;
      o_addr_pin[13:1]      = i_host.ad_out[12:0];
      o_addr_pin_oe_n[13:1] = i_host.ad_oe ? 13'h0000 : 13'h1FFF;
      o_data_pin[2:0]       = i_host.ad_out[15:13];
      o_data_pin_oe_n[2:0]  = i_host.ad_oe ? 3'h0 : 3'h7;
      o_data_pin[BMPM_D_ACK]      = i_host.host_port_ack_n;
      o_data_pin_oe_n[BMPM_D_ACK] = 1'b0;
      o_host.ad_in               = {i_data_pin[2:0], i_addr_pin[13:1]};
      o_host.host_write_strobe_n = i_data_pin[BMPM_D_WR];
      o_host.host_read_strobe_n  = i_data_pin[BMPM_D_RD];
      o_host.host_addr_latch     = i_data_pin[BMPM_D_AL];
      o_host.host_port_select_n  = i_data_pin[BMPM_D_SEL];
    end
  end

  // In host mode the low data byte belongs to the host port, so the core sees zeros there.
  assign o_core_rdata = host_mode ? {i_data_pin[23:8], 8'h00} : i_data_pin;

  // ************************************************************
  // Second serial port
  // ************************************************************
  // The switch takes effect on the next edge after the write and may be flipped at any time.
  assign o_sport_rfs        = sp_alt ? 1'b1 : i_sp1_rfs_pin;
  assign o_sport_dr         = sp_alt ? 1'b0 : i_sp1_dr_pin;
  assign o_sport_tfs        = sp_alt ? 1'b1 : i_sp1_tfs_pin;
  assign o_sp1_tfs_pin      = i_sport_tfs;
  assign o_sp1_tfs_pin_oe_n = sp_alt ? 1'b1 : ~i_sport_tfs_oe;
  assign o_sp1_dt_pin       = sp_alt ? st_ff.sysctl[BMPM_SC_FLAG_OUT] : i_sport_dt;
  assign o_sp1_dt_pin_oe_n  = sp_alt ? 1'b0 : ~i_sport_dt_oe;

endmodule
`default_nettype wire

// ---- tb/bmpm_pin_mux_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmpm_pin_mux_props
  import bmpm_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  // Bus and interrupt outputs
  input wire logic                 o_hreadyout,
  input wire logic                 o_hresp,
  input wire logic                 o_irq,
  input wire logic [BMPM_NIRQ-1:0] o_vector_req,
  // Pins
  input wire logic [7:0]           i_flag_pin,
  input wire logic [7:0]           o_flag_pin_oe_n,
  input wire logic [13:0]          o_addr_pin,
  input wire logic [13:0]          o_addr_pin_oe_n,
  input wire logic [23:0]          i_data_pin,
  input wire logic [23:0]          o_data_pin,
  input wire logic [23:0]          o_data_pin_oe_n,
  // Core and host port sides
  input wire bmpm_mem_core_t       i_core_mem,
  input wire logic                 o_host_mode,
  input wire bmpm_host_in_t        i_host,
  input wire bmpm_host_out_t       o_host
);
  // ****************************************
  // Pin and interrupt relations
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready and okay");
  a_flag_float: assert property (!$past(i_rstn) |-> o_flag_pin_oe_n == 8'hFF)
    else $error("flag pins driven before strap capture");
  a_mode_fixed: assert property ($past(i_rstn, 2) |-> $stable(o_host_mode))
    else $error("bus mode changed while running");
  a_full_addr: assert property (($past(i_rstn) && !o_host_mode) |->
    (o_addr_pin_oe_n == 14'h0000 && o_addr_pin == i_core_mem.addr))
    else $error("full mode address pins wrong");
  a_byte_addr: assert property (($past(i_rstn) && !o_host_mode && i_core_mem.byte_access) |->
    (o_data_pin[23:16] == i_core_mem.byte_addr_hi && o_data_pin_oe_n[23:16] == 8'h00))
    else $error("byte address not on upper data pins");
  a_host_a0: assert property (o_host_mode |->
    (!o_addr_pin_oe_n[0] && o_addr_pin[0] == i_core_mem.addr[0]))
    else $error("host mode address zero wrong");
  a_host_strb: assert property (o_host_mode |->
    (o_host.host_write_strobe_n == i_data_pin[BMPM_D_WR]
     && o_host.host_port_select_n == i_data_pin[BMPM_D_SEL]
     && o_data_pin[BMPM_D_ACK] == i_host.host_port_ack_n && !o_data_pin_oe_n[BMPM_D_ACK]))
    else $error("host port strobes or ack wrong");
  a_irq_level: assert property (o_irq == (o_vector_req != 6'h00))
    else $error("irq level disagrees with vector requests");
  a_lvl_cause: assert property ($rose(o_vector_req[BMPM_I_LVL1]) |->
    (!$past(i_flag_pin[BMPM_PF_LVL1]) || !$past(i_flag_pin[BMPM_PF_LVL1], 2)))
    else $error("level vector rose without a low pin");
endmodule
bind bmpm_pin_mux bmpm_pin_mux_props i_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_irq(o_irq), .o_vector_req(o_vector_req), .i_flag_pin(i_flag_pin),
  .o_flag_pin_oe_n(o_flag_pin_oe_n), .o_addr_pin(o_addr_pin),
  .o_addr_pin_oe_n(o_addr_pin_oe_n), .i_data_pin(i_data_pin), .o_data_pin(o_data_pin),
  .o_data_pin_oe_n(o_data_pin_oe_n), .i_core_mem(i_core_mem), .o_host_mode(o_host_mode),
  .i_host(i_host), .o_host(o_host));
`default_nettype wire

// ---- tb/bmpm_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmpm_far_side (
  // Clock and system setup
  input  wire logic        i_clk,
  input  wire logic        i_host,
  // Values offered by memory and host
  input  wire logic [23:0] i_mem_val,
  input  wire logic [15:0] i_host_ad,
  input  wire logic [3:0]  i_strb,
  // Device pin drivers
  input  wire logic [13:0] i_addr_out,
  input  wire logic [13:0] i_addr_oe_n,
  input  wire logic [23:0] i_data_out,
  input  wire logic [23:0] i_data_oe_n,
  // Resolved pin levels
  output logic      [13:0] o_addr_pin,
  output logic      [23:0] o_data_pin,
  output logic             o_periph_sel
);
  // Undriven address lines toggle every cycle outside host mode so that a stale level never looks valid.
  logic        tog = 1'b0;
  logic [13:0] far_a;
  logic [23:0] far_d;
  always_ff @(posedge i_clk) tog <= ~tog;
  always_comb begin
    far_a = {14{tog}};
    far_d = i_mem_val;
    if (i_host) begin
      far_a[13:1] = i_host_ad[12:0];
      far_d[7:0]  = {i_strb, tog, i_host_ad[15:13]};
    end
  end
  assign o_addr_pin = (i_addr_oe_n & far_a) | (~i_addr_oe_n & i_addr_out);
  assign o_data_pin = (i_data_oe_n & far_d) | (~i_data_oe_n & i_data_out);
  // Peripheral decode relies on the one address line left in host mode.
  assign o_periph_sel = i_host & ~o_addr_pin[0];
endmodule
`default_nettype wire

// ---- tb/bmpm_pin_mux_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bmpm_pin_mux_tb
  import bmpm_pkg::*;
;
  logic           clk, rstn, hwrite, hro, irq, rfs, dr, sdt, dt, dt_oe_n, srfs, hsys;
  logic           sdr, stfs, toe_n, psel;
  logic [1:0]     htrans;
  logic [31:0]    haddr, hwdata, hrdata, q;
  logic [7:0]     fext, fout, foe_n, fpin;
  logic [5:0]     vreq;
  logic [13:0]    ao, aoe_n, api;
  logic [23:0]    dout, doe_n, dpi, crd, mval;
  logic [15:0]    had;
  logic [3:0]     strb;
  bmpm_mem_core_t cm;
  bmpm_host_in_t  hi;
  bmpm_host_out_t ho;
  int             miscompares, tests_run;

  assign fpin = (foe_n & fext) | (~foe_n & fout);
  bmpm_pin_mux i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hro),
    .o_hrdata(hrdata), .o_hreadyout(hro), .o_hresp(), .o_irq(irq), .o_vector_req(vreq),
    .i_flag_pin(fpin), .o_flag_pin(fout), .o_flag_pin_oe_n(foe_n),
    .i_addr_pin(api), .o_addr_pin(ao), .o_addr_pin_oe_n(aoe_n),
    .i_data_pin(dpi), .o_data_pin(dout), .o_data_pin_oe_n(doe_n),
    .i_core_mem(cm), .o_core_rdata(crd), .o_host_mode(), .i_host(hi), .o_host(ho),
    .i_sp1_rfs_pin(rfs), .i_sp1_dr_pin(dr), .i_sp1_tfs_pin(1'b1), .o_sp1_tfs_pin(),
    .o_sp1_tfs_pin_oe_n(toe_n), .o_sp1_dt_pin(dt), .o_sp1_dt_pin_oe_n(dt_oe_n),
    .i_sport_tfs(1'b1), .i_sport_tfs_oe(1'b0), .i_sport_dt(sdt), .i_sport_dt_oe(sdt),
    .o_sport_rfs(srfs), .o_sport_dr(sdr), .o_sport_tfs(stfs));
  bmpm_far_side i_far (
    .i_clk(clk), .i_host(hsys), .i_mem_val(mval), .i_host_ad(had), .i_strb(strb),
    .i_addr_out(ao), .i_addr_oe_n(aoe_n), .i_data_out(dout), .i_data_oe_n(doe_n),
    .o_addr_pin(api), .o_data_pin(dpi), .o_periph_sel(psel));

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {27'h0, a};
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string n);
    ahb(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic boot(input logic [2:0] s);
    rstn <= 1'b0;
    fext <= {5'h1F, s};
    hsys <= s[BMPM_STRAP_HOST];
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    fext <= {5'h1F, ~s};
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    conclude();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rstn = 1'b0; htrans = 2'b00; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    fext = 8'hFF; rfs = 1'b1; dr = 1'b1; sdt = 1'b0; hsys = 1'b0; mval = 24'h5A0F3C;
    had = 16'h0; strb = 4'hD; cm = '0; hi = '{16'h0, 1'b0, 1'b1};
    miscompares = 0; tests_run = 0;
    boot(3'b011);
    rc(BMPM_OFS_MODE, 32'h3, "mode_full");
    cm <= '{14'h2A5A, 24'h123456, 1'b1, 1'b1, 8'hC3};
    @(negedge clk);
    chk("addr", 32'h2A5A, 32'(ao));
    chk("data", 32'hC33456, 32'(dout));
    @(posedge clk);
    cm <= '{14'h2A5A, 24'h123456, 1'b0, 1'b0, 8'hC3};
    @(negedge clk);
    chk("core_rd", 32'h5A0F3C, 32'(crd));
    wr(BMPM_OFS_MASK, 32'h3);
    wr(BMPM_OFS_FOUT, 32'h70);
    wr(BMPM_OFS_FDIR, 32'hF0);
    repeat (3) @(negedge clk);
    chk("flag_oe_n", 32'h0F, 32'(foe_n));
    chk("vec_own", 32'h1, 32'(vreq));
    chk("irq_own", 32'h1, 32'(irq));
    wr(BMPM_OFS_FOUT, 32'hF0);
    wr(BMPM_OFS_STAT, 32'h3F);
    rc(BMPM_OFS_STAT, 32'h0, "stat_clr");
    @(negedge clk);
    chk("irq_clr", 32'h0, 32'(irq));
    wr(BMPM_OFS_FDIR, 32'h0);
    fext <= 8'h2C;
    repeat (3) @(posedge clk);
    wr(BMPM_OFS_STAT, 32'h3F);
    rc(BMPM_OFS_STAT, 32'h3, "stat_lvl");
    wr(BMPM_OFS_SYSCTL, 32'h2);
    wr(BMPM_OFS_STAT, 32'h3F);
    rc(BMPM_OFS_STAT, 32'h2, "stat_edge");
    fext <= 8'hFC;
    wr(BMPM_OFS_STAT, 32'h3F);
    fext <= 8'h7C;
    rc(BMPM_OFS_STAT, 32'h1, "stat_rise");
    fext <= 8'hFC;
    rfs  <= 1'b0;
    dr   <= 1'b0;
    wr(BMPM_OFS_STAT, 32'h3F);
    rc(BMPM_OFS_STAT, 32'h0, "sp_off");
    @(negedge clk);
    chk("rfs_pass", 32'h0, 32'(srfs));
    wr(BMPM_OFS_SYSCTL, 32'h11);
    rc(BMPM_OFS_STAT, 32'h10, "sp_on");
    rc(BMPM_OFS_SYSCTL, 32'h11, "sysctl_rd");
    rc(BMPM_OFS_FIN, 32'h0FC, "fin_lo");
    dr <= 1'b1;
    rc(BMPM_OFS_FIN, 32'h1FC, "fin_hi");
    @(negedge clk);
    chk("rfs_alt", 32'h1, 32'(srfs));
    chk("fo", 32'h2, 32'({dt, dt_oe_n}));
    chk("sp_in", 32'h3, 32'({sdr, stfs, toe_n}));
    wr(BMPM_OFS_SYSCTL, 32'h15);
    wr(BMPM_OFS_STAT, 32'h3F);
    rc(BMPM_OFS_STAT, 32'h0, "sp_edge");
    wr(BMPM_OFS_SYSCTL, 32'h0);
    @(negedge clk);
    chk("rfs_back", 32'h0, 32'(srfs));
    chk("sp_back", 32'h7, 32'({sdr, stfs, toe_n}));
    @(posedge clk);
    rfs <= 1'b1;
    boot(3'b100);
    rc(BMPM_OFS_MODE, 32'hC, "mode_host");
    strb <= 4'h5;
    had  <= 16'hA5C3;
    hi   <= '{16'hBEEF, 1'b0, 1'b0};
    cm   <= '{14'h0001, 24'hABCD00, 1'b1, 1'b0, 8'h00};
    @(negedge clk);
    chk("wr_n", 32'h0, 32'(ho.host_write_strobe_n));
    chk("strb", 32'h5, 32'({ho.host_write_strobe_n, ho.host_read_strobe_n,
                            ho.host_addr_latch, ho.host_port_select_n}));
    chk("periph", 32'h0, 32'(psel));
    chk("ad_in", 32'hA5C3, 32'(ho.ad_in));
    chk("ack", 32'h0, 32'({dout[3], doe_n[3]}));
    chk("a0", 32'h2, 32'({ao[0], aoe_n[0]}));
    chk("d_hi", 32'hABCD, 32'(dout[23:8]));
    @(posedge clk);
    hi <= '{16'hBEEF, 1'b1, 1'b0};
    cm <= '{14'h0000, 24'hABCD00, 1'b1, 1'b0, 8'h00};
    @(negedge clk);
    chk("ad_out", 32'hBEEF, 32'({dout[2:0], ao[13:1]}));
    chk("periph_on", 32'h1, 32'(psel));
    conclude();
  end
endmodule
`default_nettype wire
